// ===== include/bsfc_pkg.sv
// package for the boot sector flash host controller
package bsfc_pkg;

	// ------------------------------------------------------------
	// avalon register map (word index times four)
	// ------------------------------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h4;
	localparam logic [3:0] REG_WDATA = 4'h8;
	localparam logic [3:0] REG_RDATA = 4'hc;
	localparam logic [3:0] REG_STATUS = 4'h0;

	// ------------------------------------------------------------
	// control word field positions
	// ------------------------------------------------------------
	localparam int CTRL_GO = 0;
	localparam int CTRL_OP_LSB = 1;
	localparam int CTRL_BYTE = 4;
	localparam int CTRL_WP = 5;
	localparam int CTRL_ACC = 6;
	localparam int CTRL_BYPASS = 7;
	localparam int CTRL_RESET = 8;
	localparam int CTRL_HV = 9;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [9:0] CTRL_RST = 10'h020;

	// ------------------------------------------------------------
	// pin timing in ns and cycle counts at 100 MHz
	// ------------------------------------------------------------
	localparam int CLK_NS = 10;
	localparam int ACCESS_NS = 90;
	localparam int STROBE_NS = 50;
	localparam int RESET_NS = 500;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RESET_CYC = (RESET_NS + CLK_NS - 1) / CLK_NS;

	// ------------------------------------------------------------
	// unlock command patterns, word-mode addresses
	// ------------------------------------------------------------
	localparam logic [21:0] UNLOCK_A1 = 22'h000555;
	localparam logic [21:0] UNLOCK_A2 = 22'h0002aa;
	localparam logic [15:0] UNLOCK_D1 = 16'h00aa;
	localparam logic [15:0] UNLOCK_D2 = 16'h0055;
	localparam logic [15:0] CMD_PROG = 16'h00a0;
	localparam logic [15:0] CMD_ERASE = 16'h0080;
	localparam logic [15:0] CMD_SECTOR = 16'h0030;
	localparam logic [15:0] CMD_CHIP = 16'h0010;
	localparam logic [15:0] CMD_RESET = 16'h00f0;
	localparam logic [15:0] CMD_BYPASS = 16'h0020;
	localparam logic [15:0] CMD_BYP_EXIT1 = 16'h0090;
	localparam logic [15:0] CMD_BYP_EXIT2 = 16'h0000;
	localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
	localparam logic [15:0] CMD_RESUME = 16'h0030;
	localparam logic [15:0] CMD_AUTOSEL = 16'h0090;

	// operation codes written by software
	typedef enum logic [2:0] {
		BSFC_OP_READ, BSFC_OP_WRITE, BSFC_OP_PROG, BSFC_OP_SECT_ERASE,
		BSFC_OP_CHIP_ERASE, BSFC_OP_SUSPEND, BSFC_OP_RESUME, BSFC_OP_AUTOSEL
	} bsfc_op_e;

	// flash pin bundle driven by the host
	typedef struct packed {
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic reset_n;
		logic byte_n;
	} bsfc_ctl_s;

	// one bus cycle towards the flash
	typedef struct packed {
		logic wr;
		logic [21:0] addr;
		logic [15:0] data;
	} bsfc_cyc_s;

endpackage

// ===== rtl/bsfc_host.sv
// host controller driving a parallel boot sector nor flash
//
// Overview of operation
// (RL1) hold reset low to abort, return read; the host pulses reset only from idle, so it cannot abort a running operation
// (RL2) drive protect pin low shields outer boots
// (RL3) raise protect pin high voltage for fast program
// (RL4) watch ready/busy until embedded operation ends
// (RL5) protected sectors ignore program and erase
// (RL6) protect via reset pin or high-voltage address
// (RL7) temporary unprotect entered through reset pin
// (RL8) byte-select chooses byte or word organisation
// (RL9) top data pin is lsb address in byte
// (RL10) eight boot plus sixty-three large sectors
// (RL11) device times and verifies its own pulses
// (RL12) status reads: polling, toggle, timeout bits
// (RL13) 256-byte security sector, lockable by customer
// (RL14) data bit 7 shows permanent lock state
// (RL15) security sector limited to 300 erase cycles
// (RL16) separate chip select, write, output gate
// (RL17) commands are plain write cycles, reads normal
// (RL18) device ignores writes under low supply
// (RL19) byte mode floats data pins 8 to 14
// (RL20) write: we,ce low oe high; read: ce,oe low
// (RL21) array read mode after power-up or reset
// (RL22) unlock bypass program needs two cycles only
// (RL23) standard single-supply command set used
// (RL24) busy from last command until algorithm ends
`timescale 1ns/1ns

module bsfc_host #(
	parameter int SEC_LIMIT = 300
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	// avalon-mm slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// flash address and data pins
	output logic [20:0] fl_addr_o,
	output logic [15:0] fl_dq_o,
	output logic [15:0] fl_dq_oe_o,
	input wire logic [15:0] fl_dq_i,
	// flash controls
	output bsfc_pkg::bsfc_ctl_s fl_ctl_o,
	output logic protect_accel_pin_o,
	output logic protect_accel_hv_o,
	output logic programmer_hv_addr_bit_o,
	input wire logic ready_busy_out_i
);

	typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_POLL, S_RST} bsfc_state_e;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	bsfc_state_e state_q;
	logic [9:0] ctrl_q;
	logic [21:0] addr_q;
	logic [15:0] wdata_q, rdata_q;
	logic [2:0] seq_len_q, seq_idx_q;
	logic [7:0] cnt_q;
	logic busy_q, done_q, toggle_err_q, sec_limit_q, prev_tog_q;
	logic [8:0] sec_cycles_q;
	logic [15:0] dq_s1_q, dq_s2_q;
	logic rb_s1_q, rb_s2_q;
	logic [31:0] rd_q;
	logic wait_q;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// command addresses are word addresses and byte mode doubles them; a user
	// byte address passes as is, its bit zero going out on the top data pin
	function automatic logic [21:0] pin_addr(input logic [21:0] a, input logic word_mode);
		pin_addr = word_mode ? a : {a[20:0], 1'b0}; // [RL9]
	endfunction

	// cycle n of the command sequence for the current operation
	function automatic bsfc_pkg::bsfc_cyc_s seq_cyc(input logic [2:0] op, input logic byp,
			input logic [2:0] n, input logic [21:0] a, input logic [15:0] d, input logic wm);
		bsfc_pkg::bsfc_cyc_s c;
		logic [21:0] u1, u2;
		u1 = pin_addr(bsfc_pkg::UNLOCK_A1, wm);
		u2 = pin_addr(bsfc_pkg::UNLOCK_A2, wm);
		c = '{wr: 1'b1, addr: u1, data: bsfc_pkg::UNLOCK_D1};
		if (n == 3'd1) begin
			c.addr = u2;
			c.data = bsfc_pkg::UNLOCK_D2;
		end
		case (op)
			3'(bsfc_pkg::BSFC_OP_READ): c = '{wr: 1'b0, addr: a, data: 16'h0000}; // [RL17]
			3'(bsfc_pkg::BSFC_OP_WRITE): c = '{wr: 1'b1, addr: a, data: d};
			3'(bsfc_pkg::BSFC_OP_PROG): begin
				if (byp) begin // [RL22]
					c.addr = a;
					c.data = (n == 3'd0) ? bsfc_pkg::CMD_PROG : d;
				end else if (n == 3'd2) begin
					c.data = bsfc_pkg::CMD_PROG;
				end else if (n == 3'd3) begin
					c.addr = a;
					c.data = d;
				end
			end
			3'(bsfc_pkg::BSFC_OP_SECT_ERASE), 3'(bsfc_pkg::BSFC_OP_CHIP_ERASE): begin
				if (n == 3'd2) begin
					c.data = bsfc_pkg::CMD_ERASE;
				end else if (n == 3'd5) begin
					c.addr = (op == 3'(bsfc_pkg::BSFC_OP_CHIP_ERASE)) ? u1 : a;
					c.data = (op == 3'(bsfc_pkg::BSFC_OP_CHIP_ERASE)) ? bsfc_pkg::CMD_CHIP
						: bsfc_pkg::CMD_SECTOR;
				end else if (n == 3'd4) begin
					c.addr = u2;
					c.data = bsfc_pkg::UNLOCK_D2;
				end
			end
			3'(bsfc_pkg::BSFC_OP_SUSPEND): c = '{wr: 1'b1, addr: a, data: bsfc_pkg::CMD_SUSPEND};
			3'(bsfc_pkg::BSFC_OP_RESUME): c = '{wr: 1'b1, addr: a, data: bsfc_pkg::CMD_RESUME};
			default: if (n == 3'd2) c.data = bsfc_pkg::CMD_AUTOSEL; // [RL23]
		endcase
		return c;
	endfunction

	// number of bus cycles per operation
	function automatic logic [2:0] seq_count(input logic [2:0] op, input logic byp);
		case (op)
			3'(bsfc_pkg::BSFC_OP_PROG): seq_count = byp ? 3'd2 : 3'd4;
			3'(bsfc_pkg::BSFC_OP_SECT_ERASE), 3'(bsfc_pkg::BSFC_OP_CHIP_ERASE): seq_count = 3'd6;
			3'(bsfc_pkg::BSFC_OP_AUTOSEL): seq_count = 3'd3;
			default: seq_count = 3'd1;
		endcase
	endfunction

	logic [2:0] op_w;
	logic byp_w, word_w, embedded_w, bus_rd, bus_wr, go_w;
	bsfc_pkg::bsfc_cyc_s cyc_w;
	logic [21:0] pa_w;
	assign op_w = ctrl_q[bsfc_pkg::CTRL_OP_LSB +: 3];
	// high voltage on the protect pin forces bypass mode in the part
	assign byp_w = ctrl_q[bsfc_pkg::CTRL_BYPASS] | ctrl_q[bsfc_pkg::CTRL_ACC];
	assign word_w = ~ctrl_q[bsfc_pkg::CTRL_BYTE];
	assign embedded_w = (op_w == 3'(bsfc_pkg::BSFC_OP_PROG))
		| (op_w == 3'(bsfc_pkg::BSFC_OP_SECT_ERASE)) | (op_w == 3'(bsfc_pkg::BSFC_OP_CHIP_ERASE));
	assign cyc_w = seq_cyc(op_w, byp_w, seq_idx_q, addr_q, wdata_q, word_w);
	assign pa_w = cyc_w.addr;
	assign bus_rd = avs_read_i & ~avs_write_i;
	assign bus_wr = avs_write_i;
	assign go_w = bus_wr & wait_q & (avs_address_i == bsfc_pkg::REG_CTRL)
		& avs_writedata_i[bsfc_pkg::CTRL_GO] & (state_q == S_IDLE);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	// pins come from an unclocked part, two flops before use
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dq_s1_q <= 16'h0000;
			dq_s2_q <= 16'h0000;
			rb_s1_q <= 1'b1;
			rb_s2_q <= 1'b1;
		end else if (clk_en_i) begin
			dq_s1_q <= fl_dq_i;
			dq_s2_q <= dq_s1_q;
			rb_s1_q <= ready_busy_out_i;
			rb_s2_q <= rb_s1_q;
		end
	end

	// ------------------------------------------------------------
	// avalon slave: one wait cycle, then answer
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wait_q <= 1'b0;
			rd_q <= 32'h0000_0000;
		end else if (clk_en_i) begin
			wait_q <= (bus_rd | bus_wr) & ~wait_q;
			if (bus_rd & ~wait_q) begin
				case (avs_address_i)
					bsfc_pkg::REG_STATUS: rd_q <= {17'h0, sec_cycles_q, sec_limit_q, toggle_err_q,
						done_q, busy_q, ~rb_s2_q, (state_q != S_IDLE)};
					bsfc_pkg::REG_ADDR: rd_q <= {10'h0, addr_q};
					bsfc_pkg::REG_WDATA: rd_q <= {16'h0, wdata_q};
					bsfc_pkg::REG_RDATA: rd_q <= {16'h0, rdata_q};
					default: rd_q <= 32'h0000_0000;
				endcase
			end
		end
	end
	assign avs_waitrequest_o = ~wait_q;
	assign avs_readdata_o = rd_q;

	// software registers; control write while busy keeps old op
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_q <= bsfc_pkg::CTRL_RST;
			addr_q <= 22'h000000;
			wdata_q <= 16'h0000;
		end else if (clk_en_i && bus_wr && wait_q) begin
			case (avs_address_i)
				bsfc_pkg::REG_CTRL: if (state_q == S_IDLE) ctrl_q <= avs_writedata_i[9:0];
				bsfc_pkg::REG_ADDR: addr_q <= avs_writedata_i[21:0];
				bsfc_pkg::REG_WDATA: wdata_q <= avs_writedata_i[15:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= S_IDLE;
			seq_idx_q <= 3'd0;
			seq_len_q <= 3'd0;
			cnt_q <= 8'h00;
		end else if (clk_en_i) begin
			case (state_q)
				S_IDLE: begin
					seq_idx_q <= 3'd0;
					cnt_q <= 8'h00;
					if (go_w && avs_writedata_i[bsfc_pkg::CTRL_RESET]) begin
						state_q <= S_RST; // [RL1]
					end else if (go_w) begin
						seq_len_q <= seq_count(avs_writedata_i[3:1],
							avs_writedata_i[bsfc_pkg::CTRL_BYPASS] | avs_writedata_i[bsfc_pkg::CTRL_ACC]);
						state_q <= S_SETUP;
					end
				end
				S_SETUP: state_q <= S_STROBE;
				S_STROBE: begin
					cnt_q <= cnt_q + 8'h01;
					// reads wait the access time, writes the pulse width
					if (cnt_q >= 8'(cyc_w.wr ? bsfc_pkg::STROBE_CYC : bsfc_pkg::ACCESS_CYC + 2)) begin
						cnt_q <= 8'h00;
						state_q <= S_HOLD;
					end
				end
				S_HOLD: begin
					if (seq_idx_q + 3'd1 < seq_len_q) begin
						seq_idx_q <= seq_idx_q + 3'd1;
						state_q <= S_SETUP;
					end else begin
						state_q <= embedded_w ? S_POLL : S_IDLE;
					end
				end
				S_POLL: begin
					cnt_q <= (cnt_q == 8'hff) ? cnt_q : cnt_q + 8'h01;
					// device runs its own algorithm; wait for ready [RL11] [RL4] [RL24]
					if (cnt_q > 8'h04 && rb_s2_q) state_q <= S_IDLE;
				end
				S_RST: begin
					cnt_q <= cnt_q + 8'h01;
					if (cnt_q >= 8'(bsfc_pkg::RESET_CYC)) state_q <= S_IDLE; // [RL21]
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// result capture and status flags
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_q <= 16'h0000;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			toggle_err_q <= 1'b0;
			prev_tog_q <= 1'b0;
			sec_cycles_q <= 9'h000;
			sec_limit_q <= 1'b0;
		end else if (clk_en_i) begin
			if (state_q == S_HOLD && !cyc_w.wr) begin
				rdata_q <= word_w ? dq_s2_q : {8'h00, dq_s2_q[7:0]}; // [RL19] [RL12] [RL14]
			end
			busy_q <= (state_q == S_POLL);
			if (state_q == S_POLL && rb_s2_q && cnt_q > 8'h04) done_q <= 1'b1;
			else if (go_w) done_q <= 1'b0;
			// sample toggle and timeout bits while the device is busy
			if (state_q == S_POLL) begin
				prev_tog_q <= dq_s2_q[6];
				if (dq_s2_q[5] && prev_tog_q != dq_s2_q[6]) toggle_err_q <= 1'b1; // [RL12]
			end else if (go_w) begin
				toggle_err_q <= 1'b0;
			end
			// count erase cycles on the security sector region [RL15]
			if (go_w && avs_writedata_i[3:1] == 3'(bsfc_pkg::BSFC_OP_SECT_ERASE)
					&& avs_writedata_i[bsfc_pkg::CTRL_HV] && sec_cycles_q != 9'(SEC_LIMIT)) begin
				sec_cycles_q <= sec_cycles_q + 9'h001;
			end
			sec_limit_q <= (sec_cycles_q >= 9'(SEC_LIMIT));
		end
	end

	// ------------------------------------------------------------
	// flash pins, all registered
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			fl_ctl_o <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, reset_n: 1'b0, byte_n: 1'b1};
			fl_addr_o <= 21'h000000;
			fl_dq_o <= 16'h0000;
			fl_dq_oe_o <= 16'h0000;
			protect_accel_pin_o <= 1'b1;
			protect_accel_hv_o <= 1'b0;
			programmer_hv_addr_bit_o <= 1'b0;
		end else if (clk_en_i) begin
			fl_ctl_o.byte_n <= word_w; // [RL8]
			fl_ctl_o.reset_n <= (state_q != S_RST) && !(go_w && avs_writedata_i[bsfc_pkg::CTRL_RESET]); // [RL1] [RL7]
			protect_accel_pin_o <= ctrl_q[bsfc_pkg::CTRL_WP]; // [RL2] [RL5]
			protect_accel_hv_o <= ctrl_q[bsfc_pkg::CTRL_ACC] && op_w == 3'(bsfc_pkg::BSFC_OP_PROG); // [RL3]
			programmer_hv_addr_bit_o <= ctrl_q[bsfc_pkg::CTRL_HV]; // [RL6]
			if (!word_w) fl_addr_o <= pa_w[21:1]; // [RL9]
			else fl_addr_o <= pa_w[20:0];
			// strobes: one clock of setup before, one of hold after [RL16] [RL20]
			fl_ctl_o.ce_n <= !(state_q == S_SETUP || state_q == S_STROBE);
			fl_ctl_o.we_n <= !(state_q == S_STROBE && cyc_w.wr); // [RL17]
			fl_ctl_o.oe_n <= !(state_q == S_STROBE && !cyc_w.wr);
			fl_dq_o <= word_w ? cyc_w.data : {pa_w[0], 7'h00, cyc_w.data[7:0]};
			// top pin stays driven in byte mode as the low address
			fl_dq_oe_o <= (state_q == S_SETUP || state_q == S_STROBE || state_q == S_HOLD)
				? (cyc_w.wr ? (word_w ? 16'hffff : 16'h80ff) : (word_w ? 16'h0000 : 16'h8000))
				: 16'h0000;
		end
	end

	// devices ignore writes below the inhibit level; nothing to do here [RL18]
	// sector map and security lock are the device's concern [RL10] [RL13]

endmodule

// ===== testbench/bsfc_flash_model.sv
// behavioural boot sector flash seen from its pins
`timescale 1ns/1ns
module bsfc_flash_model #(
	parameter int PROG_NS = 4000,
	parameter logic LOCKED = 1'b0
) (
	// pins from the host
	input wire logic [20:0] addr_i,
	input wire logic [15:0] dq_i,
	input wire bsfc_pkg::bsfc_ctl_s ctl_i,
	input wire logic wp_i,
	input wire logic hv_i,
	// pins towards the host
	output logic [15:0] dq_o,
	output logic rb_o
);
	// ----------------
	// array, commands, algorithm
	// ----------------
	logic [15:0] mem [logic [20:0]];
	logic [15:0] pd = 16'h0000;
	logic [15:0] last = 16'h0000;
	logic [15:0] rv;
	logic [20:0] pa;
	logic [7:0] d;
	logic [1:0] kind;
	logic [70:0] sect_prot = '0;
	logic byp = 1'b0;
	logic asel = 1'b0;
	logic tog = 1'b0;
	logic u;
	logic write_n;
	int step = 0;
	event go;
	initial rb_o = 1'b1;
	// boot sectors of 4k words at the bottom, then 32k-word sectors
	function automatic int sect(logic [20:0] a);
		return (a < 21'h008000) ? int'(a >> 12) : 8 + int'((a - 21'h008000) >> 15);
	endfunction
	function automatic logic [15:0] rd(logic [20:0] a);
		return mem.exists(a) ? mem[a] : 16'hffff;
	endfunction
	// protection is checked when the last cycle lands, not later
	task automatic start(logic [1:0] k);
		pa = addr_i;
		kind = k;
		if (!((!wp_i && sect(pa) < 2) || (sect_prot[sect(pa)] && !hv_i))) ->go;
	endtask
	// a write ends when chip select or write strobe rises first, both may rise together
	assign write_n = ctl_i.ce_n | ctl_i.we_n;
	// commands latch on the closing write edge; supply is taken as always good
	always @(posedge write_n) begin
		if (ctl_i.reset_n && rb_o) begin
			d = dq_i[7:0];
			u = addr_i[10:0] == 11'h555 && d == 8'haa;
			case (step)
				0: step = u ? 1 : ((byp || hv_i) && d == 8'ha0) ? 4 : (byp && d == 8'h90) ? 8 : 0;
				1: step = (addr_i[10:0] == 11'h2aa && d == 8'h55) ? 2 : 0;
				2: begin
					step = (d == 8'ha0) ? 4 : (d == 8'h80) ? 5 : 0;
					byp = byp | (d == 8'h20);
					asel = d == 8'h90;
				end
				5: step = u ? 6 : 0;
				6: step = (d == 8'h55) ? 7 : 0;
				7: begin
					step = 0;
					if (d == 8'h30 || d == 8'h10) start(d == 8'h10 ? 2'd2 : 2'd1);
				end
				4: begin
					step = 0;
					pd = dq_i;
					start(2'd0);
				end
				8: begin
					step = 0;
					byp = d != 8'h00;
				end
				default: step = 0;
			endcase
			if (d == 8'hf0) asel = 1'b0;
		end
	end
	// embedded algorithm times itself; programming only clears bits
	always @(go) begin : run
		rb_o = 1'b0;
		#(hv_i ? PROG_NS / 2 : PROG_NS);
		if (kind == 2'd2) begin
			mem.delete();
		end else if (kind == 2'd1) begin
			foreach (mem[k]) if (sect(k) == sect(pa)) mem[k] = 16'hffff;
		end else begin
			mem[pa] = rd(pa) & pd;
		end
		rb_o = 1'b1;
	end
	// reset pin aborts the algorithm and returns to array read
	always @(negedge ctl_i.reset_n) begin
		disable run;
		rb_o = 1'b1;
		step = 0;
		byp = 1'b0;
		asel = 1'b0;
	end
	always @(negedge ctl_i.oe_n) if (!rb_o) tog = ~tog;
	// outputs only in a selected read; else the inverse of the last value driven
	always @(ctl_i, addr_i, rb_o, dq_i[15], tog, asel) begin
		if (!rb_o) rv = {8'h00, ~pd[7], tog, 6'h00};
		else if (asel) rv = {8'h00, LOCKED, 7'h00};
		else rv = rd(addr_i);
		if (!ctl_i.byte_n) rv = {1'b0, ~last[14:8], dq_i[15] ? rv[15:8] : rv[7:0]};
		if (!ctl_i.ce_n && !ctl_i.oe_n && ctl_i.we_n && ctl_i.reset_n) begin
			dq_o = rv;
			last = rv;
		end else dq_o = ~last;
	end
endmodule

// ===== testbench/bsfc_host_bench.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ns
module bsfc_host_bench;
	// ----------------
	// signals and instances
	// ----------------
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [3:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic [20:0] fl_addr_o;
	logic [15:0] fl_dq_o, fl_dq_oe_o, fl_dq_i, dq_m;
	bsfc_pkg::bsfc_ctl_s fl_ctl_o;
	logic protect_accel_pin_o, protect_accel_hv_o, programmer_hv_addr_bit_o, ready_busy_out_i;
	logic saw_busy, saw_hv, saw_rst;
	int n_errors = 0;
	int n_checks = 0;
	assign fl_dq_i = (fl_dq_oe_o & fl_dq_o) | (~fl_dq_oe_o & dq_m);
	bsfc_host #(.SEC_LIMIT(3)) dut (.clock_i, .sys_rst_i, .clk_en_i(1'b1),
		.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
		.avs_waitrequest_o, .fl_addr_o, .fl_dq_o, .fl_dq_oe_o, .fl_dq_i, .fl_ctl_o,
		.protect_accel_pin_o, .protect_accel_hv_o, .programmer_hv_addr_bit_o, .ready_busy_out_i);
	bsfc_flash_model flash (.addr_i(fl_addr_o), .dq_i(fl_dq_i), .ctl_i(fl_ctl_o),
		.wp_i(protect_accel_pin_o), .hv_i(protect_accel_hv_o), .dq_o(dq_m), .rb_o(ready_busy_out_i));
	initial forever #5 clock_i = ~clock_i;
	// sticky pin events, cleared by the tests that look at them
	always @(posedge clock_i) begin
		if (ready_busy_out_i === 1'b0) saw_busy <= 1'b1;
		if (protect_accel_hv_o === 1'b1) saw_hv <= 1'b1;
		if (fl_ctl_o.reset_n === 1'b0 && !sys_rst_i) saw_rst <= 1'b1;
	end
	// ----------------
	// bus and compare tasks
	// ----------------
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// request held until waitrequest is seen low, then one idle edge
	task automatic bus(logic w, logic [3:0] a, logic [31:0] d, output logic [31:0] q);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge clock_i);
	endtask
	task automatic ctrl(logic [9:0] c);
		logic [31:0] s;
		bus(1'b1, bsfc_pkg::REG_CTRL, {22'h0, c}, s);
		do bus(1'b0, bsfc_pkg::REG_STATUS, 32'h0, s); while (s[0] !== 1'b0);
	endtask
	task automatic op(logic [2:0] o, logic [21:0] a, logic [15:0] d, logic [5:0] m,
		output logic [15:0] r);
		logic [31:0] q;
		bus(1'b1, bsfc_pkg::REG_ADDR, {10'h0, a}, q);
		bus(1'b1, bsfc_pkg::REG_WDATA, {16'h0, d}, q);
		ctrl({m, o, 1'b1});
		bus(1'b0, bsfc_pkg::REG_RDATA, 32'h0, q);
		r = q[15:0];
	endtask
	// ----------------
	// scenarios
	// ----------------
	task automatic t_reset;
		logic [31:0] q;
		logic [15:0] r;
		chk("pins", 32'h1f, {27'h0, fl_ctl_o});
		chk("wp pin", 32'h1, {31'h0, protect_accel_pin_o});
		bus(1'b0, 4'h2, 32'h0, q);
		chk("unmapped", 32'h0, q);
		op(bsfc_pkg::BSFC_OP_READ, 22'h000200, 16'h0, 6'h02, r);
		chk("first read", 32'hffff, {16'h0, r});
		$display("test reset done");
	endtask
	task automatic t_prog;
		logic [15:0] r;
		saw_busy = 1'b0;
		op(bsfc_pkg::BSFC_OP_PROG, 22'h010000, 16'h1234, 6'h02, r);
		chk("busy seen", 32'h1, {31'h0, saw_busy});
		op(bsfc_pkg::BSFC_OP_READ, 22'h010000, 16'h0, 6'h02, r);
		chk("prog data", 32'h1234, {16'h0, r});
		op(bsfc_pkg::BSFC_OP_READ, 22'h020001, 16'h0, 6'h03, r);
		chk("byte hi", 32'h12, {24'h0, r[7:0]});
		op(bsfc_pkg::BSFC_OP_READ, 22'h020000, 16'h0, 6'h03, r);
		chk("byte lo", 32'h34, {24'h0, r[7:0]});
		op(bsfc_pkg::BSFC_OP_SECT_ERASE, 22'h010000, 16'h0, 6'h02, r);
		op(bsfc_pkg::BSFC_OP_READ, 22'h010000, 16'h0, 6'h02, r);
		chk("erased", 32'hffff, {16'h0, r});
		$display("test program erase byte done");
	endtask
	task automatic t_prot;
		logic [15:0] r;
		op(bsfc_pkg::BSFC_OP_PROG, 22'h000100, 16'h0000, 6'h00, r);
		op(bsfc_pkg::BSFC_OP_PROG, 22'h002000, 16'h5a5a, 6'h00, r);
		op(bsfc_pkg::BSFC_OP_READ, 22'h000100, 16'h0, 6'h02, r);
		chk("boot kept", 32'hffff, {16'h0, r});
		op(bsfc_pkg::BSFC_OP_READ, 22'h002000, 16'h0, 6'h02, r);
		chk("third sector", 32'h5a5a, {16'h0, r});
		saw_hv = 1'b0;
		op(bsfc_pkg::BSFC_OP_PROG, 22'h010010, 16'h00a5, 6'h0e, r);
		chk("hv seen", 32'h1, {31'h0, saw_hv});
		op(bsfc_pkg::BSFC_OP_READ, 22'h010010, 16'h0, 6'h02, r);
		chk("bypass data", 32'h00a5, {16'h0, r});
		$display("test protect accel done");
	endtask
	task automatic t_cmds;
		logic [15:0] r;
		logic [31:0] q;
		saw_rst = 1'b0;
		ctrl(10'h121);
		chk("reset pulse", 32'h1, {31'h0, saw_rst});
		op(bsfc_pkg::BSFC_OP_READ, 22'h010010, 16'h0, 6'h02, r);
		chk("after reset", 32'h00a5, {16'h0, r});
		op(bsfc_pkg::BSFC_OP_AUTOSEL, 22'h000003, 16'h0, 6'h02, r);
		op(bsfc_pkg::BSFC_OP_READ, 22'h000003, 16'h0, 6'h02, r);
		chk("lock bit", 32'h0, {31'h0, r[7]});
		op(bsfc_pkg::BSFC_OP_WRITE, 22'h000555, 16'h00f0, 6'h02, r);
		op(bsfc_pkg::BSFC_OP_SUSPEND, 22'h0, 16'h0, 6'h02, r);
		op(bsfc_pkg::BSFC_OP_RESUME, 22'h0, 16'h0, 6'h02, r);
		op(bsfc_pkg::BSFC_OP_CHIP_ERASE, 22'h0, 16'h0, 6'h02, r);
		op(bsfc_pkg::BSFC_OP_READ, 22'h002000, 16'h0, 6'h02, r);
		chk("chip erased", 32'hffff, {16'h0, r});
		repeat (3) op(bsfc_pkg::BSFC_OP_SECT_ERASE, 22'h010000, 16'h0, 6'h22, r);
		bus(1'b0, bsfc_pkg::REG_STATUS, 32'h0, q);
		chk("security count", 32'h7, {22'h0, q[14:5]});
		chk("hv addr pin", 32'h1, {31'h0, programmer_hv_addr_bit_o});
		$display("test commands done");
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// watchdog well past the expected run of a few thousand cycles
	initial begin
		#500000;
		n_errors++;
		finish_test;
	end
	initial begin
		repeat (20) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		t_reset;
		t_prog;
		t_prot;
		t_cmds;
		finish_test;
	end
endmodule

// ===== testbench/bsfc_host_properties.sv
// concurrent checks on the flash host controller ports
`timescale 1ns/1ns
module bsfc_host_properties #(
	parameter int SEC_LIMIT = 300
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// watched ports
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	input wire logic [15:0] fl_dq_oe_o,
	input wire bsfc_pkg::bsfc_ctl_s fl_ctl_o,
	input wire logic ready_busy_out_i
);
	// ----------------
	// pin and bus protocol
	// ----------------
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	a_we_gate: assert property (!fl_ctl_o.we_n |-> fl_ctl_o.oe_n && !fl_ctl_o.ce_n)
		else $error("write strobe with gate open or chip deselected");
	a_oe_gate: assert property (!fl_ctl_o.oe_n |-> fl_ctl_o.we_n && !fl_ctl_o.ce_n)
		else $error("read gate with write strobe or chip deselected");
	a_ce_setup: assert property ($fell(fl_ctl_o.ce_n) |-> fl_ctl_o.we_n && fl_ctl_o.oe_n)
		else $error("strobe together with chip select");
	a_no_fight: assert property (|fl_dq_oe_o[14:0] |-> fl_ctl_o.oe_n)
		else $error("host drives data while flash outputs");
	a_byte_float: assert property (!fl_ctl_o.byte_n |-> fl_dq_oe_o[14:8] == 7'h00)
		else $error("upper data pins driven in byte mode");
	a_cmd_data: assert property (!fl_ctl_o.we_n && fl_ctl_o.byte_n |-> fl_dq_oe_o == 16'hffff)
		else $error("write strobe without data driven");
	a_we_width: assert property ($fell(fl_ctl_o.we_n) |=> !fl_ctl_o.we_n [*5] ##1 fl_ctl_o.we_n)
		else $error("write strobe width wrong");
	a_oe_width: assert property ($fell(fl_ctl_o.oe_n) |-> ##11 !fl_ctl_o.oe_n ##1 fl_ctl_o.oe_n)
		else $error("read gate width wrong");
	a_rst_pulse: assert property ($fell(fl_ctl_o.reset_n) |=> !fl_ctl_o.reset_n [*8] ##[40:46] fl_ctl_o.reset_n)
		else $error("hardware reset pulse length wrong");
	a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus request not answered next cycle");
	// main scenarios seen
	c_write: cover property ($fell(fl_ctl_o.we_n));
	c_busy: cover property ($fell(ready_busy_out_i));
	c_byte_read: cover property (!fl_ctl_o.byte_n && !fl_ctl_o.oe_n);
endmodule
bind bsfc_host bsfc_host_properties #(.SEC_LIMIT(SEC_LIMIT)) u_props (.clock_i, .sys_rst_i,
	.avs_read_i, .avs_write_i, .avs_waitrequest_o, .fl_dq_oe_o, .fl_ctl_o, .ready_busy_out_i);
